// ### logic/mbs_decoder.sv
// Purpose: memory map and boot select address decoder
// Assumes: one access presented per cycle, results one cycle later
// Notes: single_map_in picks the fixed unified map variant
`timescale 1ns/100ps
module mbs_decoder (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic pins_variant_in,
  input wire logic single_map_in,
  input wire logic [4:0] boot_select_pins_in,
  input wire logic [4:0] expansion_data_lines_in,
  input wire logic [4:0] host_port_data_lines_in,
  input wire logic access_valid_in,
  input wire logic [31:0] access_addr_in,
  input wire logic boot_load_done_in,
  output logic hit_valid_out,
  output logic [2:0] region_out,
  output logic [31:0] region_offset_out,
  output logic unified_ram_out,
  output logic unmapped_out,
  output logic boot_map_out,
  output logic [1:0] boot_process_out,
  output logic boot_load_out,
  output logic core_run_out,
  output logic [31:0] fetch_addr_out
);
  mbs_sel_if sel_bus ();

  // variant decides which lines are sampled
  // the variant straps are static, so this select never moves while
  // the synchroniser behind it is filling
  wire [4:0] raw_lines = single_map_in ? host_port_data_lines_in :
    (pins_variant_in ? boot_select_pins_in : expansion_data_lines_in);

  mbs_boot_latch mbs_boot_latch_inst (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .lines_in(raw_lines),
    .sel_if(sel_bus)
  );

  wire captured = sel_bus.captured;
  // high selection bit chooses boot map on dual-map parts
  wire boot_map = !single_map_in && sel_bus.sel[mbs_pkg::MAP_BIT];
  // single map: only [4:3] chooses the boot process
  wire [1:0] boot_proc = single_map_in ? sel_bus.sel[4:3] :
    sel_bus.sel[1:0];
  // single map boots through a load unless process is zero
  wire boot_mode = single_map_in ? (boot_proc != 2'h0) : boot_map;

  wire [31:0] a = access_addr_in;

  function automatic logic in_rng(input logic [31:0] addr,
      input logic [31:0] base, input logic [31:0] size);
    logic [32:0] lim;
    lim = {1'b0, base} + {1'b0, size};
    in_rng = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < lim);
  endfunction

  // common regions in both dual maps
  wire hit_periph = in_rng(a, mbs_pkg::PERIPH_BASE, mbs_pkg::SIZE_8M);
  wire hit_ext2 = in_rng(a, mbs_pkg::EXT2_BASE, mbs_pkg::SIZE_16M);
  wire hit_ext3 = in_rng(a, mbs_pkg::EXT3_BASE, mbs_pkg::SIZE_16M);
  wire hit_data = in_rng(a, mbs_pkg::DATA_BASE, mbs_pkg::DATA_SIZE);

  // direct map regions
  wire d_ext0 = in_rng(a, mbs_pkg::DIRECT_EXT0_BASE, mbs_pkg::SIZE_16M);
  wire d_ext1 = in_rng(a, mbs_pkg::DIRECT_EXT1_BASE, mbs_pkg::SIZE_4M);
  wire d_prog = in_rng(a, mbs_pkg::DIRECT_PROG_BASE, mbs_pkg::PROG_SIZE);

  // boot map regions; gap after program RAM is reserved
  wire b_prog = in_rng(a, mbs_pkg::BOOT_PROG_BASE, mbs_pkg::PROG_SIZE);
  wire b_ext0 = in_rng(a, mbs_pkg::BOOT_EXT0_BASE, mbs_pkg::SIZE_16M);
  wire b_ext1 = in_rng(a, mbs_pkg::BOOT_EXT1_BASE, mbs_pkg::SIZE_4M);

  // single map: unified RAM at zero whatever the boot
  wire u_ram = in_rng(a, mbs_pkg::UNIFIED_BASE, mbs_pkg::SIZE_64K);

  wire sel_prog = single_map_in ? 1'b0 : (boot_map ? b_prog : d_prog);
  wire sel_ext0 = !single_map_in && (boot_map ? b_ext0 : d_ext0);
  wire sel_ext1 = !single_map_in && (boot_map ? b_ext1 : d_ext1);
  wire sel_periph = hit_periph;
  wire sel_ext2 = !single_map_in && hit_ext2;
  wire sel_ext3 = !single_map_in && hit_ext3;
  wire sel_data = !single_map_in && hit_data;

  // regions are disjoint, so a priority chain gives exactly one
  mbs_pkg::mbs_region_t region_d;
  logic [31:0] base_d;
  always_comb begin
    region_d = mbs_pkg::MBS_REG_NONE;
    base_d = 32'h0000_0000;
    if (single_map_in && u_ram) begin
      region_d = mbs_pkg::MBS_REG_DATA;
      base_d = mbs_pkg::UNIFIED_BASE;
    end else if (sel_prog) begin
      region_d = mbs_pkg::MBS_REG_PROG;
      base_d = boot_map ? mbs_pkg::BOOT_PROG_BASE :
        mbs_pkg::DIRECT_PROG_BASE;
    end else if (sel_ext0) begin
      region_d = mbs_pkg::MBS_REG_EXT0;
      base_d = boot_map ? mbs_pkg::BOOT_EXT0_BASE :
        mbs_pkg::DIRECT_EXT0_BASE;
    end else if (sel_ext1) begin
      region_d = mbs_pkg::MBS_REG_EXT1;
      base_d = boot_map ? mbs_pkg::BOOT_EXT1_BASE :
        mbs_pkg::DIRECT_EXT1_BASE;
    end else if (sel_periph) begin
      region_d = mbs_pkg::MBS_REG_PERIPH;
      base_d = mbs_pkg::PERIPH_BASE;
    end else if (sel_ext2) begin
      region_d = mbs_pkg::MBS_REG_EXT2;
      base_d = mbs_pkg::EXT2_BASE;
    end else if (sel_ext3) begin
      region_d = mbs_pkg::MBS_REG_EXT3;
      base_d = mbs_pkg::EXT3_BASE;
    end else if (sel_data) begin
      region_d = mbs_pkg::MBS_REG_DATA;
      base_d = mbs_pkg::DATA_BASE;
    end
  end

  // anything else is reserved in the active map
  wire unmapped_d = region_d == mbs_pkg::MBS_REG_NONE;
  // accesses are only honoured once the map is fixed
  wire take = access_valid_in && captured;

  logic hit_valid_q;
  logic [2:0] region_q;
  logic [31:0] offset_q;
  logic unified_q;
  logic unmapped_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hit_valid_q <= 1'b0;
      region_q <= 3'h0;
      offset_q <= 32'h0000_0000;
      unified_q <= 1'b0;
      unmapped_q <= 1'b0;
    end else begin
      hit_valid_q <= take;
      if (take) begin
        region_q <= region_d;
        offset_q <= a - base_d;
        unified_q <= single_map_in && u_ram;
        unmapped_q <= unmapped_d;
      end
    end
  end

  // boot sequencer
  mbs_pkg::mbs_state_t state_q;
  mbs_pkg::mbs_state_t state_d;
  logic [7:0] load_cnt_q;
  // load ends on the loader's done, or a timeout for a stuck loader
  wire load_end = boot_load_done_in ||
    (load_cnt_q == mbs_pkg::BOOT_LOAD_CYCLES);

  always_comb begin
    state_d = state_q;
    case (state_q)
      mbs_pkg::MBS_ST_RESET: begin
        if (captured)
          state_d = boot_mode ? mbs_pkg::MBS_ST_LOAD :
            mbs_pkg::MBS_ST_RUN;
      end
      mbs_pkg::MBS_ST_LOAD: begin
        if (load_end)
          state_d = mbs_pkg::MBS_ST_RUN;
      end
      mbs_pkg::MBS_ST_RUN: state_d = mbs_pkg::MBS_ST_RUN;
      default: state_d = mbs_pkg::MBS_ST_RESET;
    endcase
  end

  // fetch start: zero when direct, external on dual-map parts, unified RAM on single map
  // internal zero after the load
  wire [31:0] fetch_d = boot_mode ? mbs_pkg::INTERNAL_FETCH_ADDR :
    mbs_pkg::DIRECT_FETCH_ADDR;

  logic boot_map_q;
  logic [1:0] boot_proc_q;
  logic load_q;
  logic run_q;
  logic [31:0] fetch_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= mbs_pkg::MBS_ST_RESET;
      load_cnt_q <= mbs_pkg::LOAD_CNT_RESET;
      boot_map_q <= 1'b0;
      boot_proc_q <= 2'h0;
      load_q <= 1'b0;
      run_q <= 1'b0;
      fetch_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (state_q == mbs_pkg::MBS_ST_LOAD && !load_end)
        load_cnt_q <= load_cnt_q + 8'h01;
      boot_map_q <= boot_map;
      boot_proc_q <= boot_proc;
      load_q <= state_d == mbs_pkg::MBS_ST_LOAD;
      run_q <= state_d == mbs_pkg::MBS_ST_RUN;
      fetch_q <= fetch_d;
    end
  end

  assign hit_valid_out = hit_valid_q;
  assign region_out = region_q;
  assign region_offset_out = offset_q;
  assign unified_ram_out = unified_q;
  assign unmapped_out = unmapped_q;
  assign boot_map_out = boot_map_q;
  assign boot_process_out = boot_proc_q;
  assign boot_load_out = load_q;
  assign core_run_out = run_q;
  assign fetch_addr_out = fetch_q;

  a_unmapped_none: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    hit_valid_out |-> (unmapped_out == (region_out == 3'h0)))
    else $error("unmapped flag disagrees with region");
  a_periph_both: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && a[31:23] == 9'h003) |=> region_out == 3'h7)
    else $error("peripheral space not decoded");
  a_direct_ext0: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && !boot_map && !single_map_in && a[31:24] == 8'h00)
      |=> region_out == 3'h3)
    else $error("direct map ext0 wrong");
  a_direct_prog: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && !boot_map && !single_map_in && a[31:16] == 16'h0140)
      |=> region_out == 3'h1)
    else $error("direct map program RAM wrong");
  a_boot_reserved: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && boot_map && a >= 32'h0001_0000 && a < 32'h0040_0000)
      |=> unmapped_out)
    else $error("boot map gap not reserved");
  a_boot_prog: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && boot_map && a[31:16] == 16'h0000) |=> region_out == 3'h1)
    else $error("boot map program RAM wrong");
  a_ext2_common: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && !single_map_in && a[31:24] == 8'h02) |=> region_out == 3'h5)
    else $error("ext2 space not decoded");
  a_ext3_common: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && !single_map_in && a[31:24] == 8'h03) |=> region_out == 3'h6)
    else $error("ext3 space not decoded");
  a_data_common: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && !single_map_in && a[31:16] == 16'h8000)
      |=> region_out == 3'h2 && !unified_ram_out)
    else $error("data RAM not decoded");
  a_unified_zero: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && single_map_in && a[31:16] == 16'h0000) |=> unified_ram_out)
    else $error("unified RAM not at zero");
  a_single_unmapped: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (take && single_map_in && a[31:16] != 16'h0000 &&
      a[31:23] != 9'h003) |=> unmapped_out)
    else $error("single map reserved space not flagged");
  a_run_after_load: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(core_run_out) && boot_mode |-> $past(boot_load_out))
    else $error("boot mode ran without loading");
  a_direct_fetch: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    (core_run_out && !boot_mode) |-> fetch_addr_out == 32'h0000_0000 &&
      !boot_load_out)
    else $error("direct fetch address wrong");
  a_load_bounded: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(boot_load_out) |-> ##[1:20] core_run_out)
    else $error("boot load never finished");
  a_map_held: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $past(core_run_out) |-> $stable(boot_map_out) &&
      $stable(boot_process_out))
    else $error("map or boot process changed while running");

  c_boot_load: cover property (@(posedge ref_clk_in)
    $rose(boot_load_out));
  c_direct_run: cover property (@(posedge ref_clk_in)
    $rose(core_run_out) && !boot_mode);
  c_unmapped: cover property (@(posedge ref_clk_in)
    hit_valid_out && unmapped_out);
  c_data_hit: cover property (@(posedge ref_clk_in)
    hit_valid_out && region_out == 3'h2);
  c_load_timeout: cover property (@(posedge ref_clk_in)
    boot_load_out && load_cnt_q == mbs_pkg::BOOT_LOAD_CYCLES);
endmodule

// ### logic/mbs_pkg.sv
// Purpose: constants and types for the memory map and boot select decoder
// Assumes: 32-bit byte addresses, one core clock
// Notes: region sizes are held as base and size pairs
package mbs_pkg;
  localparam logic [31:0] DIRECT_EXT0_BASE = 32'h0000_0000;
  localparam logic [31:0] DIRECT_EXT1_BASE = 32'h0100_0000;
  localparam logic [31:0] DIRECT_PROG_BASE = 32'h0140_0000;
  localparam logic [31:0] BOOT_PROG_BASE = 32'h0000_0000;
  localparam logic [31:0] BOOT_EXT0_BASE = 32'h0040_0000;
  localparam logic [31:0] BOOT_EXT1_BASE = 32'h0140_0000;
  localparam logic [31:0] PERIPH_BASE = 32'h0180_0000;
  localparam logic [31:0] EXT2_BASE = 32'h0200_0000;
  localparam logic [31:0] EXT3_BASE = 32'h0300_0000;
  localparam logic [31:0] DATA_BASE = 32'h8000_0000;
  localparam logic [31:0] UNIFIED_BASE = 32'h0000_0000;
  localparam logic [31:0] SIZE_16M = 32'h0100_0000;
  localparam logic [31:0] SIZE_8M = 32'h0080_0000;
  localparam logic [31:0] SIZE_4M = 32'h0040_0000;
  localparam logic [31:0] SIZE_64K = 32'h0001_0000;
  localparam logic [31:0] PROG_SIZE = 32'h0001_0000;
  localparam logic [31:0] DATA_SIZE = 32'h0001_0000;
  localparam logic [31:0] DIRECT_FETCH_ADDR = 32'h0000_0000;
  localparam logic [31:0] INTERNAL_FETCH_ADDR = 32'h0000_0000;
  localparam int SEL_W = 5;
  localparam int MAP_BIT = 4;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
  localparam logic [7:0] BOOT_LOAD_CYCLES = 8'h10;
  localparam logic [7:0] LOAD_CNT_RESET = 8'h00;
  localparam logic [1:0] SYNC_FILL_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    MBS_REG_NONE = 3'h0,
    MBS_REG_PROG = 3'h1,
    MBS_REG_DATA = 3'h2,
    MBS_REG_EXT0 = 3'h3,
    MBS_REG_EXT1 = 3'h4,
    MBS_REG_EXT2 = 3'h5,
    MBS_REG_EXT3 = 3'h6,
    MBS_REG_PERIPH = 3'h7
  } mbs_region_t;

  typedef enum logic [1:0] {
    MBS_ST_RESET = 2'h0,
    MBS_ST_LOAD = 2'h1,
    MBS_ST_RUN = 2'h2
  } mbs_state_t;
endpackage

// ### logic/mbs_sel_if.sv
// Purpose: carries the captured boot selection to the decoder
// Assumes: selection is stable after capture
// Notes: one producer, one consumer
`timescale 1ns/100ps
interface mbs_sel_if;
  logic [mbs_pkg::SEL_W-1:0] sel;
  logic captured;
  modport src (output sel, output captured);
  modport dst (input sel, input captured);
endinterface

// ### logic/mbs_boot_latch.sv
// Purpose: catch the boot selection lines once, at reset release
// Assumes: lines are held static by pull resistors around reset
// Notes: lines come from pins, so they pass two flops first
`timescale 1ns/100ps
module mbs_boot_latch (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [mbs_pkg::SEL_W-1:0] lines_in,
  mbs_sel_if.src sel_if
);
  logic [mbs_pkg::SEL_W-1:0] sync1_q;
  logic [mbs_pkg::SEL_W-1:0] sync2_q;
  logic [mbs_pkg::SEL_W-1:0] sel_q;
  logic captured_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_q <= mbs_pkg::SEL_RESET;
      sync2_q <= mbs_pkg::SEL_RESET;
    end else begin
      sync1_q <= lines_in;
      sync2_q <= sync1_q;
    end
  end

  // capture happens once the synchroniser has filled: on the third edge
  logic [1:0] fill_q;
  wire fill_done = fill_q == mbs_pkg::SYNC_FILL_CYCLES;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fill_q <= 2'h0;
      sel_q <= mbs_pkg::SEL_RESET;
      captured_q <= 1'b0;
    end else begin
      if (!fill_done)
        fill_q <= fill_q + 2'h1;
      // once captured, held until the next reset
      if (fill_done && !captured_q) begin
        sel_q <= sync2_q;
        captured_q <= 1'b1;
      end
    end
  end

  assign sel_if.sel = sel_q;
  assign sel_if.captured = captured_q;

  a_sel_held_stable: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $past(captured_q) |-> $stable(sel_q))
    else $error("boot selection changed after capture");
endmodule

// ### bench/mbs_core_model.sv
// Purpose: stand-in for the core and bus masters that issue addresses
// Assumes: one access per cycle, driven just after the rising edge
// Notes: idle address is inverted so a stale value never matches
`timescale 1ns/100ps
module mbs_core_model (
  input wire logic ref_clk_in,
  output logic access_valid_out,
  output logic [31:0] access_addr_out
);
  initial begin
    access_valid_out = 1'b0;
    access_addr_out = 32'hFFFFFFFF;
  end
  task automatic set_req(input logic v, input logic [31:0] a);
    @(posedge ref_clk_in);
    #1;
    access_valid_out = v;
    access_addr_out = v ? a : ~a;
  endtask
  // held over one edge, so the answer is already out on return
  task automatic access(input logic [31:0] a);
    set_req(1'b1, a);
    set_req(1'b0, a);
  endtask
endmodule

// ### bench/memory_map_boot_select_bench.sv
// Purpose: self-checking bench for the memory map and boot decoder
// Assumes: inputs change 1 ns after the rising edge
// Notes: load handshake timing is checked within a small window
`timescale 1ns/100ps
module memory_map_boot_select_bench;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic pins_v = 1'b1, single_m = 1'b0, done = 1'b0, boot_m = 1'b0;
  logic [4:0] pins = 5'h00, xlines = 5'h00, hlines = 5'h00;
  logic valid, hit_v, unified, unmapped, boot_map, loading, run;
  logic [31:0] addr, offset, fetch;
  logic [2:0] region;
  logic [1:0] proc;
  int num_errors = 0, check_count = 0, cycles = 0;
  localparam mbs_pkg::mbs_region_t rn = mbs_pkg::MBS_REG_NONE;
  localparam mbs_pkg::mbs_region_t rp = mbs_pkg::MBS_REG_PROG;
  localparam mbs_pkg::mbs_region_t rd = mbs_pkg::MBS_REG_DATA;
  localparam mbs_pkg::mbs_region_t r0 = mbs_pkg::MBS_REG_EXT0;
  localparam mbs_pkg::mbs_region_t r1 = mbs_pkg::MBS_REG_EXT1;
  localparam mbs_pkg::mbs_region_t r2 = mbs_pkg::MBS_REG_EXT2;
  localparam mbs_pkg::mbs_region_t r3 = mbs_pkg::MBS_REG_EXT3;
  localparam mbs_pkg::mbs_region_t rph = mbs_pkg::MBS_REG_PERIPH;

  mbs_core_model mbs_core_model_inst (
    .ref_clk_in(ref_clk_in),
    .access_valid_out(valid),
    .access_addr_out(addr)
  );
  mbs_decoder mbs_decoder_inst (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .pins_variant_in(pins_v),
    .single_map_in(single_m),
    .boot_select_pins_in(pins),
    .expansion_data_lines_in(xlines),
    .host_port_data_lines_in(hlines),
    .access_valid_in(valid),
    .access_addr_in(addr),
    .boot_load_done_in(done),
    .hit_valid_out(hit_v),
    .region_out(region),
    .region_offset_out(offset),
    .unified_ram_out(unified),
    .unmapped_out(unmapped),
    .boot_map_out(boot_map),
    .boot_process_out(proc),
    .boot_load_out(loading),
    .core_run_out(run),
    .fetch_addr_out(fetch)
  );

  always #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      $display("mismatch at %0t: run too long", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [31:0] base_of(input mbs_pkg::mbs_region_t r);
    case (r)
      rp: return boot_m ? mbs_pkg::BOOT_PROG_BASE : mbs_pkg::DIRECT_PROG_BASE;
      rd: return single_m ? mbs_pkg::UNIFIED_BASE : mbs_pkg::DATA_BASE;
      r0: return boot_m ? mbs_pkg::BOOT_EXT0_BASE : mbs_pkg::DIRECT_EXT0_BASE;
      r1: return boot_m ? mbs_pkg::BOOT_EXT1_BASE : mbs_pkg::DIRECT_EXT1_BASE;
      r2: return mbs_pkg::EXT2_BASE;
      r3: return mbs_pkg::EXT3_BASE;
      rph: return mbs_pkg::PERIPH_BASE;
      default: return 32'h00000000;
    endcase
  endfunction

  // one access, then the whole answer against the expected region
  task automatic acc(input logic [31:0] a, input mbs_pkg::mbs_region_t r);
    logic [31:0] b;
    b = base_of(r);
    mbs_core_model_inst.access(a);
    check_count++;
    if (hit_v !== 1'b1 || region !== r || offset !== a - b ||
        unmapped !== (r == rn) || unified !== (single_m & (r == rd))) begin
      num_errors++;
      $display("mismatch at %0t: access %h", $time, a);
    end
  endtask

  // an early access is refused; returns just after the fourth edge
  task automatic bring_up(input logic pv, input logic sm, input logic [4:0] p,
                          input logic [4:0] x, input logic [4:0] h);
    reset_n_in = 1'b0;
    pins_v = pv;
    single_m = sm;
    pins = p;
    xlines = x;
    hlines = h;
    boot_m = sm ? 1'b0 : (pv ? p[4] : x[4]);
    repeat (10) @(posedge ref_clk_in);
    #1;
    reset_n_in = 1'b1;
    mbs_mbs_wait();
  endtask
  task automatic mbs_mbs_wait();
    mbs_core_model_inst.set_req(1'b1, 32'h01800000);
    mbs_core_model_inst.set_req(1'b0, 32'h01800000);
    // an answer to the access held over edge two would stand right now
    chk(32'(hit_v), 32'h0, "early access answered");
    @(posedge ref_clk_in);
    #1;
    @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (run !== 1'b1 && n < 40) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
  endtask

  task automatic t_direct();
    bring_up(1'b1, 1'b0, 5'h00, 5'h1F, 5'h1F);
    chk(32'(run), 32'h1, "direct run");
    chk(32'(loading), 32'h0, "direct load");
    chk(32'(boot_map), 32'h0, "pin map");
    chk(fetch, mbs_pkg::DIRECT_FETCH_ADDR, "fetch");
    acc(32'h00000000, r0);
    acc(32'h00FFFFFF, r0);
    acc(32'h01000000, r1);
    acc(32'h013FFFFF, r1);
    acc(32'h01400000, rp);
    acc(32'h0140FFFF, rp);
    acc(32'h01410000, rn);
    acc(32'h017FFFFF, rn);
    acc(32'h01800000, rph);
    acc(32'h01FFFFFF, rph);
    acc(32'h02000000, r2);
    acc(32'h02FFFFFF, r2);
    acc(32'h03000000, r3);
    acc(32'h03FFFFFF, r3);
    acc(32'h04000000, rn);
    acc(32'h80000000, rd);
    acc(32'h8000FFFF, rd);
    acc(32'h80010000, rn);
    acc(32'hFFFFFFFF, rn);
    pins = 5'h1F;
    acc(32'h00000000, r0);
    chk(32'(boot_map), 32'h0, "map held");
    chk(32'(proc), 32'h0, "process held");
  endtask

  // pins say direct, the pulled expansion lines say boot: lines win
  task automatic t_boot();
    int n;
    bring_up(1'b0, 1'b0, 5'h00, 5'h11, 5'h00);
    chk(32'(boot_map), 32'h1, "line map");
    chk(32'(proc), 32'h1, "line process");
    chk(32'(loading), 32'h1, "load busy");
    chk(32'(run), 32'h0, "run in load");
    repeat (3) @(posedge ref_clk_in);
    #1;
    done = 1'b1;
    wait_run(n);
    done = 1'b0;
    chk(32'(n >= 1 && n <= 2), 32'h1, "run after done");
    chk(32'(loading), 32'h0, "load ended");
    chk(fetch, mbs_pkg::INTERNAL_FETCH_ADDR, "boot fetch");
    acc(32'h00000000, rp);
    acc(32'h0000FFFF, rp);
    acc(32'h00010000, rn);
    acc(32'h003FFFFF, rn);
    acc(32'h00400000, r0);
    acc(32'h013FFFFF, r0);
    acc(32'h01400000, r1);
    acc(32'h017FFFFF, r1);
    acc(32'h01800000, rph);
    acc(32'h80000000, rd);
  endtask

  task automatic t_boot_timeout();
    int n;
    bring_up(1'b1, 1'b0, 5'h12, 5'h00, 5'h00);
    chk(32'(proc), 32'h2, "pin process");
    wait_run(n);
    chk(32'(n >= 15 && n <= 17), 32'h1, "load timeout");
    chk(32'(loading), 32'h0, "timeout load");
  endtask

  // single map ignores the pins and the low host lines
  task automatic t_single();
    int n;
    bring_up(1'b1, 1'b1, 5'h10, 5'h10, 5'h13);
    chk(32'(proc), 32'h2, "host process");
    chk(32'(boot_map), 32'h0, "one map");
    chk(32'(loading), 32'h1, "host load");
    done = 1'b1;
    wait_run(n);
    done = 1'b0;
    chk(32'(n), 32'h1, "host load end");
    chk(32'(loading), 32'h0, "host load off");
    acc(32'h00000000, rd);
    acc(32'h0000FFFF, rd);
    acc(32'h00010000, rn);
    acc(32'h01800000, rph);
    acc(32'h80000000, rn);
    bring_up(1'b1, 1'b1, 5'h10, 5'h10, 5'h07);
    chk(32'(proc), 32'h0, "host direct");
    chk(32'(run), 32'h1, "host run");
    acc(32'h00000000, rd);
  endtask

  initial begin
    t_direct();
    t_boot();
    t_boot_timeout();
    t_single();
    tally_and_finish();
  end
endmodule
